/* core/ssl_dev.sv */
// Purpose: Serial controller with status flags, shared data buffer and LIN break length.
// Assumes: Avalon-MM slave with one wait cycle; line input is synchronous to clk.
// Notes: Bit time is 16 slots of (divisor + 1) clocks each.
`timescale 1ns/10ps
module ssl_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic [ssl_pkg::SSL_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ssl_pkg::SSL_DW-1:0] avs_writedata,
  output logic [ssl_pkg::SSL_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq,
  output logic err_irq,
  // Line
  ssl_link_if.dev link
);
  import ssl_pkg::*;
  logic ack_r, rd_done, wr_done, tick;
  logic [7:0] ctl2_r, ctl3_r, baud_r, stat1, stat2, rdmux;
  logic [7:0] arm1_r;
  logic arm2_r;
  logic [3:0] div_r;
  logic txe_r, txd_r, rxf_r, idl_r, ovr_r, nf_r, fe_r, pe_r, brk_r, act_r, rx9_r;
  logic [7:0] rxbuf_r, txbuf_r;
  logic nine, rxd, te_d_r, re_d_r, idle_ok_r, rearm_r;
  ssl_rx_st_t rx_st_r;
  ssl_tx_st_t tx_st_r;
  logic [3:0] rslot_r, rbit_r, tslot_r;
  logic [9:0] rsh_r;
  logic s_a_r, s_b_r;
  logic [7:0] icnt_r;
  logic ev_r, ev_brk_r, ev_fe_r, ev_pe_r, ev_nf_r, ev_idle_r, nf_acc_r;
  logic [8:0] ev_data_r;
  logic [15:0] tsh_r;
  logic [4:0] tleft_r;
  logic pre_r, tail_r, brk_run_r, txpin_r, pend, load_data;
  logic [10:0] tframe;
  logic clr_rd;
  logic [7:0] idle_ticks;

  assign nine = ctl3_r[SSL_C3_NINE];
  assign rxd = link.node_txd;
  assign link.dev_txd = txpin_r;

  // One wait cycle gives the read mux a full cycle before data must stand.
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack_r & ce);
  assign rd_done = avs_read & ack_r & ce;
  assign wr_done = avs_write & ack_r & ce;
  assign clr_rd = rd_done && (avs_address == SSL_OFS_DATA);
  // Sixteen slots for every bit of a whole character of ones.
  assign idle_ticks = 8'({ssl_frame_len(nine), 4'h0});

  assign stat1 = {txe_r, txd_r, rxf_r, idl_r, ovr_r, nf_r, fe_r, pe_r};
  assign stat2 = {6'h00, brk_r, act_r};
  always_comb begin
    case (avs_address)
      SSL_OFS_STAT1: rdmux = stat1;
      SSL_OFS_STAT2: rdmux = stat2;
      SSL_OFS_CTL2: rdmux = ctl2_r;
      SSL_OFS_CTL3: rdmux = {rx9_r, ctl3_r[6:0]};
      SSL_OFS_BAUD: rdmux = baud_r;
      SSL_OFS_DATA: rdmux = rxbuf_r;
      default: rdmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read && !ack_r) begin
        avs_readdata <= {24'h000000, rdmux};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl2_r <= SSL_RST_CTL;
      ctl3_r <= SSL_RST_CTL;
      baud_r <= SSL_RST_BAUD;
    end else if (wr_done) begin
      if (avs_address == SSL_OFS_CTL2) ctl2_r <= avs_writedata[7:0];
      if (avs_address == SSL_OFS_CTL3) ctl3_r <= {1'b0, avs_writedata[6:0]};
      if (avs_address == SSL_OFS_BAUD) baud_r <= {1'b0, avs_writedata[6:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arm1_r <= 8'h00;
      arm2_r <= 1'b0;
    end else if (ce) begin
      if (rd_done && avs_address == SSL_OFS_STAT1) arm1_r <= avs_readdata[7:0];
      else if (clr_rd) arm1_r[SSL_S1_RXF:0] <= '0;
      else if (wr_done && avs_address == SSL_OFS_DATA) arm1_r[SSL_S1_TXE] <= 1'b0;
      if (rd_done && avs_address == SSL_OFS_STAT2) arm2_r <= avs_readdata[SSL_S2_BRK];
      else if (clr_rd) arm2_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_done && avs_address == SSL_OFS_DATA) txbuf_r <= avs_writedata[7:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= 4'h0;
    end else if (ce) begin
      div_r <= tick ? baud_r[3:0] : div_r - 4'h1;
    end
  end
  assign tick = ce && (div_r == 4'h0);

  // Receiver: start search, three-sample majority per bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_r <= SSL_RX_IDLE;
      rslot_r <= 4'h0;
      rbit_r <= 4'h0;
      rsh_r <= 10'h000;
      s_a_r <= 1'b0;
      s_b_r <= 1'b0;
      act_r <= 1'b0;
      icnt_r <= 8'h00;
      ev_r <= 1'b0;
      ev_idle_r <= 1'b0;
      nf_acc_r <= 1'b0;
    end else if (ce) begin
      ev_r <= 1'b0;
      ev_idle_r <= 1'b0;
      if (!ctl2_r[SSL_C2_RE]) begin
        rx_st_r <= SSL_RX_IDLE;
        act_r <= 1'b0;
        icnt_r <= 8'h00;
      end else if (tick) begin
        rslot_r <= rslot_r + 4'h1;
        if (rslot_r == SSL_SLOT_A) s_a_r <= rxd;
        if (rslot_r == SSL_SLOT_B) s_b_r <= rxd;
        case (rx_st_r)
          SSL_RX_IDLE: begin
            rslot_r <= 4'h1;
            if (!rxd) begin
              // A start needs a one first, so a long break is not read twice.
              if (icnt_r != 8'h00) begin
                rx_st_r <= SSL_RX_START;
                act_r <= 1'b1;
                icnt_r <= 8'h00;
              end
            end else if (icnt_r == idle_ticks - 8'h01) begin
              // idle after full character of ones
              ev_idle_r <= 1'b1;
              act_r <= 1'b0;
              icnt_r <= icnt_r + 8'h01;
            end else if (icnt_r < idle_ticks) begin
              icnt_r <= icnt_r + 8'h01;
            end
          end
          SSL_RX_START: begin
            if (rslot_r == SSL_SLOT_B && rxd) begin
              rx_st_r <= SSL_RX_IDLE;
              act_r <= 1'b0;
            end else if (rslot_r == SSL_SLOTS_LAST) begin
              rx_st_r <= SSL_RX_BITS;
              rbit_r <= 4'h0;
              nf_acc_r <= 1'b0;
            end
          end
          SSL_RX_BITS: begin
            if (rslot_r == SSL_SLOT_C) begin
              rsh_r[rbit_r] <= (s_a_r & s_b_r) | (s_a_r & rxd) | (s_b_r & rxd);
              if (!(s_a_r == s_b_r && s_b_r == rxd)) nf_acc_r <= 1'b1;
              if (rbit_r == 4'(ssl_frame_len(nine) - 5'h02)) begin
                rx_st_r <= SSL_RX_IDLE;
                ev_r <= 1'b1;
                act_r <= 1'b0;
              end
            end
            if (rslot_r == SSL_SLOTS_LAST) rbit_r <= rbit_r + 4'h1;
          end
          default: rx_st_r <= SSL_RX_IDLE;
        endcase
      end
    end
  end

  // Decode the finished character.
  always_comb begin
    ev_data_r = nine ? rsh_r[8:0] : {rsh_r[7], rsh_r[7:0]};
    ev_fe_r = nine ? ~rsh_r[9] : ~rsh_r[8];
    ev_brk_r = nine ? (rsh_r == 10'h000) : (rsh_r[8:0] == 9'h000);
    ev_nf_r = nf_acc_r;
    // parity in the top data bit
    ev_pe_r = baud_r[SSL_BD_PEN] &
              ((nine ? ^rsh_r[8:0] : ^rsh_r[7:0]) ^ baud_r[SSL_BD_PODD]);
  end

  always_ff @(posedge clk) begin
    if (ce && ev_r && !rxf_r) begin
      rxbuf_r <= ev_brk_r ? 8'h00 : ev_data_r[7:0];
      rx9_r <= ev_brk_r ? 1'b0 : ev_data_r[8];
    end
  end

  // Receive flags; a set in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxf_r <= 1'b0;
      idl_r <= 1'b0;
      ovr_r <= 1'b0;
      nf_r <= 1'b0;
      fe_r <= 1'b0;
      pe_r <= 1'b0;
      brk_r <= 1'b0;
      rearm_r <= 1'b1;
      idle_ok_r <= 1'b0;
      re_d_r <= 1'b0;
    end else if (ce) begin
      re_d_r <= ctl2_r[SSL_C2_RE];
      if (clr_rd && arm1_r[SSL_S1_RXF]) rxf_r <= 1'b0;
      if (clr_rd && arm1_r[SSL_S1_IDL]) idl_r <= 1'b0;
      if (clr_rd && arm1_r[SSL_S1_OVR]) ovr_r <= 1'b0;
      if (clr_rd && arm1_r[SSL_S1_NF]) nf_r <= 1'b0;
      if (clr_rd && arm1_r[SSL_S1_FE]) fe_r <= 1'b0;
      if (clr_rd && arm1_r[SSL_S1_PE]) pe_r <= 1'b0;
      if (clr_rd && arm2_r) brk_r <= 1'b0;
      if (rx_st_r == SSL_RX_IDLE && rxd) rearm_r <= 1'b1;
      // idle needs a valid character first
      if ((ctl2_r[SSL_C2_RE] && !re_d_r) || (clr_rd && arm1_r[SSL_S1_IDL])) begin
        idle_ok_r <= 1'b0;
      end
      if (ev_idle_r && idle_ok_r) idl_r <= 1'b1;
      if (ev_r) begin
        if (rxf_r && !(clr_rd && arm1_r[SSL_S1_RXF])) begin
          ovr_r <= 1'b1;
        end else begin
          rxf_r <= 1'b1;
          idle_ok_r <= 1'b1;
          if (ev_nf_r) nf_r <= 1'b1;
          if (ev_fe_r) fe_r <= 1'b1;
          if (ev_pe_r && !ev_brk_r) pe_r <= 1'b1;
          if (ev_brk_r && rearm_r) brk_r <= 1'b1;
          if (ev_brk_r) rearm_r <= 1'b0;
        end
      end
    end
  end

  // Transmit side.
  assign pend = ctl2_r[SSL_C2_TE] & (pre_r | ctl2_r[SSL_C2_SBK] | tail_r | ~txe_r);
  assign load_data = tx_st_r == SSL_TX_IDLE && ctl2_r[SSL_C2_TE] && !pre_r &&
                     !ctl2_r[SSL_C2_SBK] && !tail_r && !txe_r;
  always_comb begin
    tframe = nine ? {1'b1, ctl3_r[SSL_C3_TX9], txbuf_r, 1'b0} : {2'b11, txbuf_r, 1'b0};
    if (baud_r[SSL_BD_PEN] && nine) tframe[9] = ^txbuf_r ^ baud_r[SSL_BD_PODD];
    if (baud_r[SSL_BD_PEN] && !nine) tframe[8] = ^txbuf_r[6:0] ^ baud_r[SSL_BD_PODD];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_r <= SSL_TX_IDLE;
      tslot_r <= 4'h0;
      tleft_r <= 5'h00;
      tsh_r <= 16'hFFFF;
      pre_r <= 1'b0;
      tail_r <= 1'b0;
      brk_run_r <= 1'b0;
      te_d_r <= 1'b0;
      txpin_r <= 1'b1;
    end else if (ce) begin
      te_d_r <= ctl2_r[SSL_C2_TE];
      if (ctl2_r[SSL_C2_TE] && !te_d_r) pre_r <= 1'b1;
      txpin_r <= (tx_st_r == SSL_TX_RUN) ? tsh_r[0] : 1'b1;
      case (tx_st_r)
        SSL_TX_IDLE: begin
          tslot_r <= 4'h0;
          if (pend) begin
            tx_st_r <= SSL_TX_RUN;
            brk_run_r <= 1'b0;
            if (pre_r) begin
              pre_r <= 1'b0;
              tsh_r <= 16'hFFFF;
              tleft_r <= ssl_frame_len(nine);
            end else if (ctl2_r[SSL_C2_SBK]) begin
              tsh_r <= 16'h0000;
              brk_run_r <= 1'b1;
              tleft_r <= !baud_r[SSL_BD_EXT] ? ssl_frame_len(nine) :
                         (nine ? SSL_EXT_BRK9 : SSL_EXT_BRK8);
            end else if (tail_r) begin
              tail_r <= 1'b0;
              tsh_r <= 16'hFFFF;
              tleft_r <= 5'h01;
            end else begin
              tsh_r <= {5'h1F, tframe};
              tleft_r <= ssl_frame_len(nine);
            end
          end
        end
        SSL_TX_RUN: begin
          if (tick) begin
            tslot_r <= tslot_r + 4'h1;
            if (tslot_r == SSL_SLOTS_LAST) begin
              tsh_r <= {1'b1, tsh_r[15:1]};
              tleft_r <= tleft_r - 5'h01;
              if (tleft_r == 5'h01) begin
                tx_st_r <= SSL_TX_IDLE;
                if (brk_run_r && !ctl2_r[SSL_C2_SBK]) tail_r <= 1'b1;
              end
            end
          end
        end
        default: tx_st_r <= SSL_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txe_r <= 1'b1;
      txd_r <= 1'b1;
    end else if (ce) begin
      if (wr_done && avs_address == SSL_OFS_DATA && arm1_r[SSL_S1_TXE]) txe_r <= 1'b0;
      if (load_data) txe_r <= 1'b1;
      txd_r <= txe_r & ~load_data & (tx_st_r == SSL_TX_IDLE) & ~pend;
    end
  end

  assign tx_irq = (ctl2_r[SSL_C2_TXEIE] & txe_r) | (ctl2_r[SSL_C2_TXDIE] & txd_r);
  assign rx_irq = (ctl2_r[SSL_C2_RXFIE] & rxf_r) | (ctl2_r[SSL_C2_IDLIE] & idl_r);
  assign err_irq = (ctl3_r[SSL_C3_OVRIE] & ovr_r) | (ctl3_r[SSL_C3_NFIE] & nf_r) |
                   (ctl3_r[SSL_C3_FRAMING_IRQ_ENABLE] & fe_r) | (ctl3_r[SSL_C3_PARITY_IRQ_ENABLE] & pe_r);
endmodule

/* common/ssl_pkg.sv */
// Purpose: Shared constants and helpers for the serial status, data and LIN break ends.
// Assumes: One bus clock; 16 sample slots per bit time.
package ssl_pkg;
  localparam int SSL_AW = 8;
  localparam int SSL_DW = 32;
  localparam logic [7:0] SSL_OFS_STAT1 = 8'h00;
  localparam logic [7:0] SSL_OFS_STAT2 = 8'h04;
  localparam logic [7:0] SSL_OFS_CTL2 = 8'h08;
  localparam logic [7:0] SSL_OFS_CTL3 = 8'h0C;
  localparam logic [7:0] SSL_OFS_BAUD = 8'h10;
  localparam logic [7:0] SSL_OFS_DATA = 8'h18;
  // Status one bit positions.
  localparam int SSL_S1_TXE = 7;
  localparam int SSL_S1_TXD = 6;
  localparam int SSL_S1_RXF = 5;
  localparam int SSL_S1_IDL = 4;
  localparam int SSL_S1_OVR = 3;
  localparam int SSL_S1_NF = 2;
  localparam int SSL_S1_FE = 1;
  localparam int SSL_S1_PE = 0;
  // Status two bit positions.
  localparam int SSL_S2_BRK = 1;
  localparam int SSL_S2_ACT = 0;
  // Control two bit positions.
  localparam int SSL_C2_TXEIE = 7;
  localparam int SSL_C2_TXDIE = 6;
  localparam int SSL_C2_RXFIE = 5;
  localparam int SSL_C2_IDLIE = 4;
  localparam int SSL_C2_TE = 3;
  localparam int SSL_C2_RE = 2;
  localparam int SSL_C2_SBK = 0;
  // Control three bit positions.
  localparam int SSL_C3_RX9 = 7;
  localparam int SSL_C3_TX9 = 6;
  localparam int SSL_C3_NINE = 5;
  localparam int SSL_C3_OVRIE = 3;
  localparam int SSL_C3_NFIE = 2;
  localparam int SSL_C3_FRAMING_IRQ_ENABLE = 1;
  localparam int SSL_C3_PARITY_IRQ_ENABLE = 0;
  // Baud select bit positions; low nibble is the slot divisor.
  localparam int SSL_BD_EXT = 6;
  localparam int SSL_BD_PEN = 5;
  localparam int SSL_BD_PODD = 4;
  // Reset values.
  localparam logic [7:0] SSL_RST_CTL = 8'h00;
  localparam logic [7:0] SSL_RST_BAUD = 8'h00;
  // Timing counts.
  localparam logic [3:0] SSL_SLOTS_LAST = 4'hF;
  localparam logic [3:0] SSL_SLOT_A = 4'h7;
  localparam logic [3:0] SSL_SLOT_B = 4'h8;
  localparam logic [3:0] SSL_SLOT_C = 4'h9;
  localparam logic [4:0] SSL_EXT_BRK8 = 5'h0D;
  localparam logic [4:0] SSL_EXT_BRK9 = 5'h0E;
  localparam logic [4:0] SSL_FRAME8 = 5'h0A;
  localparam logic [4:0] SSL_FRAME9 = 5'h0B;

  typedef enum logic [1:0] {SSL_RX_IDLE, SSL_RX_START, SSL_RX_BITS} ssl_rx_st_t;
  typedef enum logic [0:0] {SSL_TX_IDLE, SSL_TX_RUN} ssl_tx_st_t;

  // Bits in a whole character: start, data and stop.
  function automatic logic [4:0] ssl_frame_len(input logic nine);
    return nine ? SSL_FRAME9 : SSL_FRAME8;
  endfunction
endpackage

/* common/ssl_link_if.sv */
// Purpose: Serial line pair between the controller and the remote node.
// Assumes: Both ends run on the same clock; lines idle high.
// Notes: Push-pull lines, no tristate.
`timescale 1ns/10ps
interface ssl_link_if;
  logic dev_txd;
  logic node_txd;
  modport dev(output dev_txd, input node_txd);
  modport node(input dev_txd, output node_txd);
endinterface

/* core/ssl_node.sv */
// Purpose: Remote serial node that sends and receives plain characters.
// Assumes: Bit time is a whole number of clocks, given by the user.
// Notes: A break is sent as a zero frame of the requested bit count, at most 12 bits.
`timescale 1ns/10ps
module ssl_node (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Line format
  input wire logic [15:0] bit_cycles,
  input wire logic nine,
  // Send side
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [8:0] send_data,
  input wire logic send_break,
  input wire logic [4:0] break_bits,
  // Receive side
  output logic recv_valid,
  output logic [8:0] recv_data,
  output logic recv_frame_err,
  // Line
  ssl_link_if.node link
);
  import ssl_pkg::*;
  logic [15:0] tcnt_r;
  logic [4:0] tleft_r;
  logic [11:0] tsh_r;
  logic [15:0] rcnt_r;
  logic [3:0] rbit_r;
  logic rbusy_r;
  logic [10:0] rsh_r;
  logic [4:0] nbits;

  assign nbits = ssl_frame_len(nine);
  assign send_ready = (tleft_r == 5'h00);
  assign link.node_txd = tsh_r[0] | send_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      tcnt_r <= 16'h0000;
      tleft_r <= 5'h00;
      tsh_r <= 12'hFFF;
    end else if (ce) begin
      if (send_ready && send_valid) begin
        tcnt_r <= bit_cycles;
        tleft_r <= send_break ? break_bits : nbits;
        tsh_r <= send_break ? 12'h000 :
                 (nine ? {1'b1, 1'b1, send_data, 1'b0} : {2'b11, 1'b1, send_data[7:0], 1'b0});
      end else if (!send_ready) begin
        if (tcnt_r <= 16'h0001) begin
          tcnt_r <= bit_cycles;
          tleft_r <= tleft_r - 5'h01;
          tsh_r <= {1'b1, tsh_r[11:1]};
        end else begin
          tcnt_r <= tcnt_r - 16'h0001;
        end
      end
    end
  end

  // Receiver samples each bit in its middle.
  always_ff @(posedge clk) begin
    if (rst) begin
      rcnt_r <= 16'h0000;
      rbit_r <= 4'h0;
      rbusy_r <= 1'b0;
      rsh_r <= 11'h000;
      recv_valid <= 1'b0;
      recv_data <= 9'h000;
      recv_frame_err <= 1'b0;
    end else if (ce) begin
      recv_valid <= 1'b0;
      if (!rbusy_r) begin
        if (!link.dev_txd) begin
          rbusy_r <= 1'b1;
          rcnt_r <= {1'b0, bit_cycles[15:1]};
          rbit_r <= 4'h0;
        end
      end else if (rcnt_r <= 16'h0001) begin
        rcnt_r <= bit_cycles;
        rsh_r[rbit_r] <= link.dev_txd;
        if (rbit_r == 4'(nbits - 5'h01)) begin
          rbusy_r <= 1'b0;
          recv_valid <= 1'b1;
          recv_data <= nine ? rsh_r[9:1] : {1'b0, rsh_r[8:1]};
          recv_frame_err <= ~link.dev_txd;
        end
        rbit_r <= rbit_r + 4'h1;
      end else begin
        rcnt_r <= rcnt_r - 16'h0001;
      end
    end
  end
endmodule

/* dv/ssl_chk_sva.sv */
// Purpose: Checks bus answer timing, flag clearing causes and break lengths.
// Assumes: Bit time of 16 clocks (divisor 0); ce held high.
// Notes: A break is judged from the run of zeros on the device line.
`timescale 1ns/10ps
module ssl_chk_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [ssl_pkg::SSL_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ssl_pkg::SSL_DW-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Requests and line
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic err_irq,
  input wire logic dev_txd
);
  import ssl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_ok;
  logic wr_ok;
  logic [9:0] zrun_r;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wr_ok = avs_write && !avs_waitrequest;
  // Zeros counted in clocks, so bit boundaries show as multiples of 16.
  always_ff @(posedge clk) begin
    if (rst || dev_txd) begin
      zrun_r <= 10'h000;
    end else begin
      zrun_r <= zrun_r + 10'h001;
    end
  end
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  property p_wait;
    $rose(avs_read || avs_write) |-> s_one_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("Bus answer not after one wait.");
  property p_upper;
    rd_ok |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("Upper read bits set.");
  property p_stat2;
    rd_ok && avs_address == SSL_OFS_STAT2 |-> avs_readdata[7:2] == 6'h00;
  endproperty
  a_stat2: assert property (p_stat2) else $error("Unused status two bits set.");
  property p_rst;
    $fell(rst) |-> dev_txd && !tx_irq && !rx_irq && !err_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("Outputs wrong after reset.");
  // Queueing clears done up to three edges after the write that queues it.
  property p_txclr;
    $fell(tx_irq) |-> $past(wr_ok) || $past(wr_ok, 2) || $past(wr_ok, 3);
  endproperty
  a_txclr: assert property (p_txclr) else $error("Tx request fell without write.");
  property p_rxclr;
    $fell(rx_irq) |-> $past(rd_ok && avs_address == SSL_OFS_DATA || wr_ok);
  endproperty
  a_rxclr: assert property (p_rxclr) else $error("Rx request fell alone.");
  property p_errclr;
    $fell(err_irq) |-> $past(rd_ok && avs_address == SSL_OFS_DATA || wr_ok);
  endproperty
  a_errclr: assert property (p_errclr) else $error("Error request fell alone.");
  property p_brk;
    $rose(dev_txd) |-> zrun_r <= 10'h0B0 || zrun_r == 10'h0D0 || zrun_r == 10'h0E0;
  endproperty
  a_brk: assert property (p_brk) else $error("Zero run of wrong length.");
  property p_bit;
    $rose(dev_txd) |-> zrun_r[3:0] == 4'h0;
  endproperty
  a_bit: assert property (p_bit) else $error("Zero run not whole bits.");
endmodule

/* dv/test_serial_status_data_lin_break.sv */
// Purpose: Drives the controller and the remote node over one link and judges results.
// Assumes: Divisor 0 gives 16 clocks a bit; ce held high.
// Notes: Noise detection is not stimulated; the node cannot disturb single samples.
`timescale 1ns/10ps
module test_serial_status_data_lin_break;
  import ssl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [SSL_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [SSL_DW-1:0] avs_writedata = '0;
  logic [SSL_DW-1:0] avs_readdata;
  logic avs_waitrequest, tx_irq, rx_irq, err_irq, send_ready, recv_valid, recv_frame_err;
  logic send_valid = 1'b0;
  logic send_break = 1'b0;
  logic [8:0] send_data = '0;
  logic [8:0] recv_data;
  logic [7:0] rd;
  logic [15:0] zc = '0;
  logic [15:0] zlast = '0;
  logic [7:0] vcnt = '0;
  int error_cnt = 0;
  int samples_checked = 0;
  ssl_link_if link();
  ssl_dev u_ssl_dev (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .err_irq(err_irq), .link(link.dev));
  ssl_node u_ssl_node (.clk(clk), .rst(rst), .ce(1'b1), .bit_cycles(16'h0010), .nine(1'b0),
    .send_valid(send_valid), .send_ready(send_ready), .send_data(send_data),
    .send_break(send_break), .break_bits(5'h0B), .recv_valid(recv_valid),
    .recv_data(recv_data), .recv_frame_err(recv_frame_err), .link(link.node));
  ssl_chk_sva u_ssl_chk_sva (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .err_irq(err_irq), .dev_txd(link.dev_txd));
  always #25 clk = ~clk;
  // Last zero run on the device line, in clocks, and characters seen by the node.
  always @(posedge clk) begin
    if (recv_valid === 1'b1) vcnt <= vcnt + 8'h01;
    if (link.dev_txd === 1'b0) begin
      zc <= zc + 16'h0001;
    end else begin
      if (zc != 16'h0000) zlast <= zc;
      zc <= 16'h0000;
    end
  end
  task end_sim;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge.
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      end_sim;
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, rd & m}, {8'h00, e});
  endtask
  function automatic logic ev(input int k);
    return (k == 0) ? rx_irq : (k == 2) ? send_ready : tx_irq;
  endfunction
  task wait_ev(input int k, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ev(k) !== 1'b1 && n < lim);
    if (ev(k) !== 1'b1) begin
      error_cnt++;
      end_sim;
    end
    @(posedge clk);
  endtask
  task node_tx(input logic brk, input logic [8:0] d);
    wait_ev(2, 400);
    send_data <= d;
    send_break <= brk;
    send_valid <= 1'b1;
    @(posedge clk);
    send_valid <= 1'b0;
    @(posedge clk);
    wait_ev(2, 400);
  endtask
  task t_reset;
    bus(1'b1, 8'h14, 8'hFF);
    rdc(8'h14, 8'hFF, 8'h00);
    rdc(SSL_OFS_STAT1, 8'hFF, 8'hC0);
    rdc(SSL_OFS_STAT2, 8'hFF, 8'h00);
    rdc(SSL_OFS_BAUD, 8'hFF, SSL_RST_BAUD);
    rdc(SSL_OFS_CTL2, 8'hFF, SSL_RST_CTL);
  endtask
  task t_txirq;
    bus(1'b1, SSL_OFS_CTL2, 8'h80);
    chk({15'h0000, tx_irq}, 16'h0001);
    bus(1'b1, SSL_OFS_CTL2, 8'h40);
    chk({15'h0000, tx_irq}, 16'h0001);
    bus(1'b1, SSL_OFS_CTL2, 8'h00);
    chk({15'h0000, tx_irq}, 16'h0000);
  endtask
  task t_tx;
    bus(1'b1, SSL_OFS_CTL2, 8'h4C);
    @(posedge clk);
    rdc(SSL_OFS_STAT1, 8'h40, 8'h00);
    bus(1'b1, SSL_OFS_DATA, 8'hA5);
    rdc(SSL_OFS_STAT1, 8'hC0, 8'h00);
    wait_ev(3, 800);
    chk({7'h00, recv_data}, 16'h00A5);
    chk({15'h0000, recv_frame_err}, 16'h0000);
    chk({8'h00, vcnt}, 16'h0001);
    rdc(SSL_OFS_STAT1, 8'hC0, 8'hC0);
  endtask
  task t_rx;
    bus(1'b1, SSL_OFS_CTL2, 8'h2C);
    node_tx(1'b0, 9'h011);
    chk({15'h0000, rx_irq}, 16'h0001);
    node_tx(1'b0, 9'h022);
    rdc(SSL_OFS_STAT1, 8'h2F, 8'h28);
    rdc(SSL_OFS_DATA, 8'hFF, 8'h11);
    chk({15'h0000, rx_irq}, 16'h0000);
    node_tx(1'b0, 9'h033);
    rdc(SSL_OFS_STAT1, 8'h08, 8'h00);
    node_tx(1'b0, 9'h044);
    rdc(SSL_OFS_DATA, 8'hFF, 8'h33);
    rdc(SSL_OFS_STAT1, 8'h28, 8'h08);
    rdc(SSL_OFS_DATA, 8'hFF, 8'h33);
    bus(1'b1, SSL_OFS_CTL2, 8'h1C);
    wait_ev(0, 400);
    rdc(SSL_OFS_STAT1, 8'h10, 8'h10);
    rdc(SSL_OFS_DATA, 8'h00, 8'h00);
    bus(1'b1, SSL_OFS_CTL2, 8'h18);
    bus(1'b1, SSL_OFS_CTL2, 8'h1C);
    repeat (400) @(posedge clk);
    rdc(SSL_OFS_STAT1, 8'h10, 8'h00);
    chk({15'h0000, rx_irq}, 16'h0000);
  endtask
  task t_err;
    bus(1'b1, SSL_OFS_CTL3, 8'h03);
    node_tx(1'b1, 9'h000);
    chk({15'h0000, err_irq}, 16'h0001);
    rdc(SSL_OFS_STAT2, 8'h02, 8'h02);
    rdc(SSL_OFS_STAT1, 8'h23, 8'h22);
    rdc(SSL_OFS_DATA, 8'hFF, 8'h00);
    rdc(SSL_OFS_STAT2, 8'h02, 8'h00);
    chk({15'h0000, err_irq}, 16'h0000);
    bus(1'b1, SSL_OFS_BAUD, 8'h20);
    node_tx(1'b0, 9'h001);
    rdc(SSL_OFS_STAT1, 8'h03, 8'h01);
    chk({15'h0000, err_irq}, 16'h0001);
    rdc(SSL_OFS_DATA, 8'h00, 8'h00);
    chk({15'h0000, err_irq}, 16'h0000);
  endtask
  task t_brk;
    logic [23:0] cs [3];
    cs = '{24'h4000D0, 24'h4020E0, 24'h0020B0};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, SSL_OFS_BAUD, cs[i][23:16]);
      bus(1'b1, SSL_OFS_CTL3, cs[i][15:8]);
      bus(1'b1, SSL_OFS_CTL2, 8'h49);
      bus(1'b1, SSL_OFS_CTL2, 8'h48);
      wait_ev(3, 800);
      chk(zlast, {8'h00, cs[i][7:0]});
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_txirq;
    t_tx;
    t_rx;
    t_err;
    t_brk;
    end_sim;
  end
  // Whole run needs under 10000 clocks.
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
